// File: common/pcisb_map.svh
// pcisb_map.svh: offsets, field positions, reset values and fixed codes
// assumes: included by bare name from design modules
`ifndef PCISB_MAP_SVH
`define PCISB_MAP_SVH
// ==========================================
// offsets
`define PCISB_CFG_INTR_OFF 8'h3C
`define PCISB_STAT_OFF 12'h100
`define PCISB_MASK_OFF 12'h104
// ==========================================
// read-only configuration fields
`define PCISB_MAXLAT_VAL 8'hFF
`define PCISB_MINGNT_VAL 8'h04
`define PCISB_INTPIN_VAL 8'h01
`define PCISB_LAT_UNIT_NS 250
// ==========================================
// reset values
`define PCISB_INTLINE_RST 32'h0000_0000
`define PCISB_MASK_RST 32'h0000_0000
// ==========================================
// status field positions
`define PCISB_B_PSTAT 28
`define PCISB_B_RUN 27
`define PCISB_B_SYNC 19
`define PCISB_B_OPC 18
`define PCISB_B_ABORT 17
`define PCISB_B_IPERR 16
`define PCISB_B_BUS_PARITY_ERROR 15
`define PCISB_B_RESYNC 14
`define PCISB_B_FIFO_TARGET_LATENCY_OVERRUN 13
`define PCISB_B_FDROP 12
`define PCISB_B_PIRQ 11
`define PCISB_B_AOVF 3
`define PCISB_FLAG_MASK 32'h000F_F808
`endif

// File: common/pcisb_pkg.sv
// pcisb_pkg: types shared by the interrupt status block
// assumes: nothing beyond the map header
`default_nettype none
package pcisb_pkg;
  typedef logic [31:0] pcisb_word_t;
  typedef logic [3:0] pcisb_be_t;
  typedef enum logic [1:0]
  {
    PCISB_SP_NONE = 2'h0,
    PCISB_SP_CFG = 2'h1,
    PCISB_SP_STAT = 2'h3,
    PCISB_SP_MASK = 2'h2
  } pcisb_space_e;
endpackage
`default_nettype wire

// File: common/pcisb_wr_if.sv
// pcisb_wr_if: one register write strobe with byte enables and data
// assumes: driven by the decode in the top module, one cycle per write
`default_nettype none
interface pcisb_wr_if;
  import pcisb_pkg::*;
  logic wr;
  pcisb_be_t be;
  pcisb_word_t wdata;
  modport src (output wr, output be, output wdata);
  modport snk (input wr, input be, input wdata);
endinterface
`default_nettype wire

// File: src/pcisb_lane_reg.sv
// pcisb_lane_reg: read/write register written per byte lane
// assumes: a selected write strobe from the decode, same clock and reset
`default_nettype none
module pcisb_lane_reg
  import pcisb_pkg::*;
#(
  parameter logic [31:0] RST_VAL = 32'h0000_0000,
  parameter logic [31:0] BIT_MASK = 32'hFFFF_FFFF
)
(
  input wire logic clk,
  input wire logic arst_n,
  pcisb_wr_if.snk wif,
  output logic [31:0] q
);
  logic [31:0] q_reg;
  assign q = q_reg;
  // ==========================================
  // one process per lane; unimplemented bits stay zero
  for (genvar l = 0; l < 4; l++)
  begin : g_lane
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        q_reg[l*8 +: 8] <= RST_VAL[l*8 +: 8] & BIT_MASK[l*8 +: 8];
      else if (wif.wr && wif.be[l])
        q_reg[l*8 +: 8] <= wif.wdata[l*8 +: 8] & BIT_MASK[l*8 +: 8];
    end
  end
endmodule
`default_nettype wire

// File: src/pcisb_flag_bank.sv
// pcisb_flag_bank: sticky event flags cleared by writing ones
// assumes: set pulses and write strobe on the same clock
`default_nettype none
module pcisb_flag_bank
  import pcisb_pkg::*;
#(
  parameter logic [31:0] FLAG_MASK = 32'hFFFF_FFFF
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [31:0] set_vec,
  pcisb_wr_if.snk wif,
  output logic [31:0] flags
);
  logic [31:0] flags_reg;
  logic [31:0] clr_vec;
  assign flags = flags_reg;
  // ==========================================
  // per bit: set beats a clear in the same cycle
  for (genvar i = 0; i < 32; i++)
  begin : g_bit
    assign clr_vec[i] = wif.wr && wif.be[i/8] && wif.wdata[i];
    if (FLAG_MASK[i])
    begin : g_flag
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          flags_reg[i] <= 1'b0;
        else if (set_vec[i])
          flags_reg[i] <= 1'b1;
        else if (clr_vec[i])
          flags_reg[i] <= 1'b0;
      end
    end
    else
    begin : g_rsvd
      assign flags_reg[i] = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: src/pcisb_top.sv
// pcisb_top: interrupt status collection and local register decode
// assumes: a PCI target front end turns bus cycles into one-cycle read
// and write strobes with dword index and byte enables; event inputs
// are one-cycle pulses on the PCI clock
`default_nettype none
`include "pcisb_map.svh"

module pcisb_top
  import pcisb_pkg::*;
#(
  parameter int MASK_W = 24
)
(
  input wire logic clk,
  input wire logic arst_n,

  input wire logic acc_cfg,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [11:2] acc_addr,
  input wire logic [3:0] acc_be,
  input wire logic [31:0] acc_wdata,
  output logic [31:0] acc_rdata,
  output logic acc_ack,

  input wire logic parity_err_resp,
  input wire logic fetch_en_set,
  input wire logic fetch_en_clr,

  input wire logic instr_exec,
  input wire logic [3:0] instr_set_bits,
  input wire logic [3:0] instr_clr_bits,
  input wire logic instr_irq,
  input wire logic sync_cnt_ovf,
  input wire logic sync_mismatch,
  input wire logic rsvd_opcode,
  input wire logic rsvd_sync_status,
  input wire logic instr_error,
  input wire logic master_abort,
  input wire logic target_abort,
  input wire logic fetch_data_perr,
  input wire logic bus_perr,
  input wire logic stream_resync,
  input wire logic fifo_tgt_overrun,
  input wire logic fifo_drop_overrun,
  input wire logic audio_ovf,

  output logic program_fetch_enable,
  output logic inta_o,
  output logic inta_oe
);
  // ==========================================
  // elaboration checks
  // narrower than 20 bits would leave flags without a mask bit
  if (MASK_W < 20 || MASK_W > 32)
  begin : g_bad_mask_w
    $error("mask width must cover flag bits 19:0 and fit a dword");
  end

  localparam logic [31:0] MASK_BITS = 32'hFFFF_FFFF >> (32 - MASK_W);

  // every flag needs a mask bit, or it could never interrupt
  if ((`PCISB_FLAG_MASK & ~MASK_BITS) != 32'h0000_0000)
  begin : g_unmaskable
    $error("mask width leaves a flag without a mask bit");
  end

  // ==========================================
  // declarations
  pcisb_space_e space;
  logic [31:0] lane_mask;

  logic [31:0] cfg_word;
  logic [31:0] stat_word;
  logic [31:0] mask_q;
  logic [31:0] intline_q;

  logic [31:0] flags;
  logic [31:0] set_vec;
  logic [31:0] pend_vec;
  logic [31:0] rd_word;

  logic [3:0] pstat_reg;
  logic fetch_en_reg;
  logic fetch_stop;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic intr_reg;
  logic inta_o_reg;

  logic iperr_evt;
  logic sync_evt;
  logic opc_evt;
  logic abort_evt;
  logic bus_parity_error_evt;
  logic pirq_evt;

  pcisb_wr_if cfg_wif ();
  pcisb_wr_if stat_wif ();
  pcisb_wr_if mask_wif ();

  // ==========================================
  // decode
  // only bits 11:2 select a register inside the 4 kB window
  always_comb
  begin
    if (acc_cfg && acc_addr[7:2] == 6'(`PCISB_CFG_INTR_OFF >> 2))
      space = PCISB_SP_CFG;
    else if (acc_cfg)
      space = PCISB_SP_NONE;
    else if (acc_addr == 10'(`PCISB_STAT_OFF >> 2))
      space = PCISB_SP_STAT;
    else if (acc_addr == 10'(`PCISB_MASK_OFF >> 2))
      space = PCISB_SP_MASK;
    else
      space = PCISB_SP_NONE;
  end

  for (genvar l = 0; l < 4; l++)
  begin : g_lmask
    assign lane_mask[l*8 +: 8] = {8{acc_be[l]}};
  end

  // ==========================================
  // write strobes toward the storage modules
  assign cfg_wif.wr = acc_wr && space == PCISB_SP_CFG;
  assign cfg_wif.be = acc_be;
  assign cfg_wif.wdata = acc_wdata;

  // a read never touches the flags; only a write strobe clears
  assign stat_wif.wr = acc_wr && space == PCISB_SP_STAT;
  assign stat_wif.be = acc_be;
  assign stat_wif.wdata = acc_wdata;

  assign mask_wif.wr = acc_wr && space == PCISB_SP_MASK;
  assign mask_wif.be = acc_be;
  assign mask_wif.wdata = acc_wdata;

  // ==========================================
  // configuration dword
  pcisb_lane_reg #(
    .RST_VAL(`PCISB_INTLINE_RST),
    .BIT_MASK(32'h0000_00FF)
  ) u_intline (
    .clk(clk),
    .arst_n(arst_n),
    .wif(cfg_wif),
    .q(intline_q)
  );

  assign cfg_word[31:24] = `PCISB_MAXLAT_VAL;
  assign cfg_word[23:16] = `PCISB_MINGNT_VAL;
  assign cfg_word[15:8] = `PCISB_INTPIN_VAL;
  assign cfg_word[7:0] = intline_q[7:0];

  // ==========================================
  // mask register
  pcisb_lane_reg #(
    .RST_VAL(`PCISB_MASK_RST),
    .BIT_MASK(MASK_BITS)
  ) u_mask (
    .clk(clk),
    .arst_n(arst_n),
    .wif(mask_wif),
    .q(mask_q)
  );

  // ==========================================
  // event collection
  // fetch parity sets the IPERR flag only when response is enabled
  assign iperr_evt = fetch_data_perr && parity_err_resp;
  // either sync fault means the field must be restarted
  assign sync_evt = sync_cnt_ovf || sync_mismatch;
  assign opc_evt = rsvd_opcode || rsvd_sync_status || instr_error;
  assign abort_evt = master_abort || target_abort;
  // bus parity is recorded whatever the response enable says
  assign bus_parity_error_evt = bus_perr || fetch_data_perr;
  // the irq bit only counts on an executed instruction
  assign pirq_evt = instr_exec && instr_irq;

  always_comb
  begin
    set_vec = 32'h0000_0000;
    set_vec[`PCISB_B_SYNC] = sync_evt;
    set_vec[`PCISB_B_OPC] = opc_evt;
    set_vec[`PCISB_B_ABORT] = abort_evt;
    set_vec[`PCISB_B_IPERR] = iperr_evt;
    set_vec[`PCISB_B_BUS_PARITY_ERROR] = bus_parity_error_evt;
    set_vec[`PCISB_B_RESYNC] = stream_resync;
    set_vec[`PCISB_B_FIFO_TARGET_LATENCY_OVERRUN] = fifo_tgt_overrun;
    set_vec[`PCISB_B_FDROP] = fifo_drop_overrun;
    set_vec[`PCISB_B_PIRQ] = pirq_evt;
    set_vec[`PCISB_B_AOVF] = audio_ovf;
  end

  // reserved positions are not even built, so they read zero
  pcisb_flag_bank #(
    .FLAG_MASK(`PCISB_FLAG_MASK)
  ) u_flags (
    .clk(clk),
    .arst_n(arst_n),
    .set_vec(set_vec),
    .wif(stat_wif),
    .flags(flags)
  );

  // ==========================================
  // program status bits, read-only
  // a set and a reset of the same bit in one instruction: set wins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pstat_reg <= 4'h0;
    else if (instr_exec)
      pstat_reg <= instr_set_bits | (pstat_reg & ~instr_clr_bits);
  end

  // ==========================================
  // program fetch enable
  // parity stop has priority over a software enable in the same cycle
  assign fetch_stop = iperr_evt || fetch_en_clr;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      fetch_en_reg <= 1'b0;
    else if (fetch_stop)
      fetch_en_reg <= 1'b0;
    else if (fetch_en_set)
      fetch_en_reg <= 1'b1;
  end

  assign program_fetch_enable = fetch_en_reg;

  // ==========================================
  // status word assembly
  always_comb
  begin
    stat_word = flags & `PCISB_FLAG_MASK;
    // run bit mirrors the live fetch enable
    stat_word[31:28] = pstat_reg;
    stat_word[`PCISB_B_RUN] = fetch_en_reg;
  end

  // ==========================================
  // read answer
  // unmapped offsets answer zero so probing software sees no garbage
  always_comb
  begin
    if (space == PCISB_SP_CFG)
      rd_word = cfg_word;
    else if (space == PCISB_SP_STAT)
      rd_word = stat_word;
    else if (space == PCISB_SP_MASK)
      rd_word = mask_q;
    else
      rd_word = 32'h0000_0000;
  end

  // one register per lane so a disabled lane reads zero
  for (genvar l = 0; l < 4; l++)
  begin : g_rlane
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        rdata_reg[l*8 +: 8] <= 8'h00;
      else if (acc_rd)
        rdata_reg[l*8 +: 8] <= rd_word[l*8 +: 8] & lane_mask[l*8 +: 8];
    end
  end

  // every read or write is answered one cycle later, no wait states
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= acc_rd || acc_wr;
  end

  assign acc_rdata = rdata_reg;
  assign acc_ack = ack_reg;

  // ==========================================
  // interrupt output, open drain, active low
  // level follows flags and mask; costs one cycle of latency
  assign pend_vec = flags & mask_q & `PCISB_FLAG_MASK;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      intr_reg <= 1'b0;
    else
      intr_reg <= |pend_vec;
  end

  // data pin held low; only the enable moves
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      inta_o_reg <= 1'b0;
    else
      inta_o_reg <= 1'b0;
  end

  assign inta_oe = intr_reg;
  assign inta_o = inta_o_reg;
endmodule
`default_nettype wire

// File: sim/pcisb_host_model.sv
// pcisb_host_model: host side of the interrupt wire
// assumes: inta_o/inta_oe from pcisb_top, pull-up on the line
`default_nettype none
module pcisb_host_model
(
  input wire logic inta_o,
  input wire logic inta_oe,
  output logic inta_n
);
  // ==========
  // released line floats to the pull-up, never to the last value
  assign inta_n = inta_oe ? inta_o : 1'b1;
endmodule
`default_nettype wire

// File: sim/pcisb_assertions.sv
// pcisb_assertions: port-level checks on pcisb_top
// assumes: one clock, async active-low reset
`default_nettype none
module pcisb_assertions
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic acc_cfg,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [11:2] acc_addr,
  input wire logic [3:0] acc_be,
  input wire logic [31:0] acc_wdata,
  input wire logic [31:0] acc_rdata,
  input wire logic acc_ack,
  input wire logic parity_err_resp,
  input wire logic fetch_data_perr,
  input wire logic audio_ovf,
  input wire logic program_fetch_enable,
  input wire logic inta_o,
  input wire logic inta_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========
  wire rd_stat = acc_rd && !acc_cfg && acc_addr == 10'h040 && acc_be == 4'hF;
  wire wr_stat = acc_wr && !acc_cfg && acc_addr == 10'h040 && acc_be == 4'hF;
  sequence s_clr3;
    wr_stat && acc_wdata[3] && !audio_ovf;
  endsequence
  sequence s_poll;
    rd_stat && !audio_ovf;
  endsequence
  // ==========
  AST_ACK: assert property ((acc_rd || acc_wr) |=> acc_ack)
    else $error("access not acknowledged");
  AST_ACK_CAUSE: assert property (acc_ack |-> $past(acc_rd || acc_wr))
    else $error("ack without access");
  AST_CFG_FIXED: assert property (acc_rd && acc_cfg && acc_addr[7:2] == 6'h0F && acc_be == 4'hF
    |=> acc_rdata[31:8] == 24'hFF0401)
    else $error("fixed config fields wrong");
  AST_RSVD: assert property (rd_stat |=> (acc_rdata & 32'h07F0_07F7) == 32'h0)
    else $error("reserved status bits not zero");
  AST_LANE_OFF: assert property (acc_rd && !acc_be[0] |=> acc_rdata[7:0] == 8'h00)
    else $error("disabled lane returned data");
  AST_PERR_STOP: assert property (fetch_data_perr && parity_err_resp
    |=> !program_fetch_enable)
    else $error("fetch not stopped on parity error");
  AST_RUN_BIT: assert property (rd_stat |=> acc_rdata[27] == $past(program_fetch_enable))
    else $error("run bit differs from fetch enable");
  AST_W1C: assert property (s_clr3 ##1 !audio_ovf ##1 rd_stat |=> !acc_rdata[3])
    else $error("flag not cleared by one");
  AST_POLL: assert property (s_poll ##1 (!audio_ovf && !acc_wr) ##1 rd_stat
    |=> acc_rdata[3] == $past(acc_rdata[3]))
    else $error("read altered a flag");
  AST_AOVF_SET: assert property (audio_ovf ##1 !acc_wr ##1 rd_stat |=> acc_rdata[3])
    else $error("audio flag not set");
  AST_INTA_LOW: assert property (inta_oe |-> !inta_o)
    else $error("interrupt driven high");
  AST_INTA_HOLD: assert property (inta_oe && !acc_wr && !$past(acc_wr) |=> inta_oe)
    else $error("interrupt dropped without clear");
endmodule
bind pcisb_top pcisb_assertions u_pcisb_assertions (.clk(clk), .arst_n(arst_n),
  .acc_cfg(acc_cfg), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_be(acc_be),
  .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack),
  .parity_err_resp(parity_err_resp), .fetch_data_perr(fetch_data_perr), .audio_ovf(audio_ovf),
  .program_fetch_enable(program_fetch_enable), .inta_o(inta_o), .inta_oe(inta_oe));
`default_nettype wire

// File: sim/test_pci_interrupt_status_block.sv
// test_pci_interrupt_status_block: register-call tests of pcisb_top
// assumes: strobes driven at falling edges, one access per two cycles
`default_nettype none
module test_pci_interrupt_status_block import pcisb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, acc_cfg = 1'b0, acc_rd = 1'b0, acc_wr = 1'b0, per = 1'b0;
  logic fen_set = 1'b0, fen_clr = 1'b0, exec = 1'b0, acc_ack, pfe, inta_o, inta_oe, inta_n;
  logic [11:2] acc_addr = 10'h000;
  logic [3:0] acc_be = 4'h0, iset = 4'h0, iclr = 4'h0;
  logic [13:0] ev = 14'h0;
  pcisb_word_t acc_wdata = 32'h0, acc_rdata, rd;
  int n_errors = 0, comparisons = 0;
  // event index -> flags expected (parity response on)
  pcisb_word_t exp_ev [14] = '{32'h0008_0000, 32'h0008_0000, 32'h0004_0000, 32'h0004_0000,
    32'h0004_0000, 32'h0002_0000, 32'h0002_0000, 32'h0001_8000, 32'h0000_8000,
    32'h0000_4000, 32'h0000_2000, 32'h0000_1000, 32'h0000_0008, 32'h0000_0800};
  pcisb_top u_pcisb_top (.clk(clk), .arst_n(arst_n), .acc_cfg(acc_cfg), .acc_rd(acc_rd),
    .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_be(acc_be), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_ack(acc_ack), .parity_err_resp(per), .fetch_en_set(fen_set),
    .fetch_en_clr(fen_clr), .instr_exec(exec | ev[13]), .instr_set_bits(iset),
    .instr_clr_bits(iclr), .instr_irq(ev[13]), .sync_cnt_ovf(ev[0]), .sync_mismatch(ev[1]),
    .rsvd_opcode(ev[2]), .rsvd_sync_status(ev[3]), .instr_error(ev[4]),
    .master_abort(ev[5]), .target_abort(ev[6]), .fetch_data_perr(ev[7]), .bus_perr(ev[8]),
    .stream_resync(ev[9]), .fifo_tgt_overrun(ev[10]), .fifo_drop_overrun(ev[11]),
    .audio_ovf(ev[12]), .program_fetch_enable(pfe), .inta_o(inta_o), .inta_oe(inta_oe));
  pcisb_host_model u_pcisb_host_model (.inta_o(inta_o), .inta_oe(inta_oe), .inta_n(inta_n));
  // ==========
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input pcisb_word_t seen, input pcisb_word_t exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic cfg, input logic wr, input logic [11:2] a,
      input logic [3:0] be, input pcisb_word_t wd);
    @(negedge clk);
    acc_cfg = cfg;
    acc_rd = !wr;
    acc_wr = wr;
    acc_addr = a;
    acc_be = be;
    acc_wdata = wd;
    @(negedge clk);
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    rd = acc_rdata;
    chk({31'h0, acc_ack}, 32'h1);
  endtask
  task automatic rs(input pcisb_word_t exp);
    xfer(1'b0, 1'b0, 10'h040, 4'hF, 32'h0);
    chk(rd, exp);
  endtask
  task automatic fire(input logic [13:0] e, input logic [3:0] s, input logic [3:0] c);
    @(negedge clk);
    ev = e;
    iset = s;
    iclr = c;
    exec = |{s, c};
    @(negedge clk);
    ev = 14'h0;
    exec = 1'b0;
  endtask
  // ==========
  initial
  begin
    #50000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    xfer(1'b1, 1'b0, 10'h00F, 4'hF, 32'h0);
    chk(rd, 32'hFF04_0100);
    xfer(1'b1, 1'b1, 10'h00F, 4'h1, 32'hAAAA_AA5B);
    xfer(1'b1, 1'b0, 10'h00F, 4'hF, 32'h0);
    chk(rd, 32'hFF04_015B);
    xfer(1'b1, 1'b0, 10'h00F, 4'h2, 32'h0);
    chk(rd, 32'h0000_0100);
    xfer(1'b0, 1'b0, 10'h3FF, 4'hF, 32'h0);
    chk(rd, 32'h0);
    per = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      fire(14'h1 << i, 4'h0, 4'h0);
      repeat (2) rs(exp_ev[i]);
      xfer(1'b0, 1'b1, 10'h040, 4'hF, rd);
      rs(32'h0);
    end
    fire(14'h0, 4'hA, 4'h0);
    fire(14'h0, 4'h1, 4'h8);
    fen_set = 1'b1;
    @(negedge clk);
    fen_set = 1'b0;
    xfer(1'b0, 1'b1, 10'h040, 4'hF, 32'hFFFF_FFFF);
    rs(32'h3800_0000);
    fire(14'h0080, 4'h0, 4'h0);
    rs(32'h3001_8000);
    xfer(1'b0, 1'b1, 10'h040, 4'hF, 32'hFFFF_FFFF);
    fen_set = 1'b1;
    per = 1'b0;
    @(negedge clk);
    fen_set = 1'b0;
    fire(14'h0080, 4'h0, 4'h0);
    rs(32'h3800_8000);
    fen_clr = 1'b1;
    @(negedge clk);
    fen_clr = 1'b0;
    xfer(1'b0, 1'b1, 10'h041, 4'hF, 32'hFFFF_FFFF);
    xfer(1'b0, 1'b0, 10'h041, 4'hF, 32'h0);
    chk(rd, 32'h00FF_FFFF);
    xfer(1'b0, 1'b1, 10'h041, 4'hF, 32'h0000_0008);
    fire(14'h1000, 4'h0, 4'h0);
    xfer(1'b0, 1'b1, 10'h040, 4'h2, 32'hFFFF_FFFF);
    rs(32'h3000_0008);
    chk({31'h0, inta_n}, 32'h0);
    repeat (5) @(negedge clk);
    chk({31'h0, inta_n}, 32'h0);
    xfer(1'b0, 1'b1, 10'h041, 4'h1, 32'h0);
    @(negedge clk);
    chk({31'h0, inta_n}, 32'h1);
    xfer(1'b0, 1'b1, 10'h041, 4'h1, 32'h0000_0008);
    @(negedge clk);
    chk({31'h0, inta_n}, 32'h0);
    xfer(1'b0, 1'b1, 10'h040, 4'h1, 32'h0000_0008);
    @(negedge clk);
    chk({31'h0, inta_n}, 32'h1);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chk({31'h0, inta_n}, 32'h1);
    rs(32'h0);
    xfer(1'b1, 1'b0, 10'h00F, 4'hF, 32'h0);
    chk(rd, 32'hFF04_0100);
    wrap_up();
  end
endmodule
`default_nettype wire
